// File: verilog/csi_pkg.sv
// Purpose: shared constants and types of the converter serial interface
// Assumes: APB byte addresses, 32-bit data, one register per word
// Notes: registers hold the low 16 bits, upper bits read zero
//
// Behaviour
// - serial transfers start only after the module enable bit 15 is set
// - master loads transmit words and frames at once; slave waits for sync
// - enabling sets transmit-empty and the interface flag immediately
// - first frame end sets transmit-empty and receive-full, flag raised
// - reading a receive holding register clears receive-full
// - writing a transmit holding register clears transmit-empty
// - clearing enable finishes the frame in progress, servicing continues
// - disable inside the last 3 bit clocks costs one extra frame
// - after disable no sync is driven and incoming sync is ignored
// - at final slot after disable engine goes idle, pins released
// - idle shows slot status zero while enable reads zero
// - entering idle moves pending receive words to holding, flags updated
// - sync direction bit 8: zero frame master, one frame slave
// - master drives a sync each time the frame generator restarts
// - slave multi-channel starts a frame one bit after sync sampled high
// - slave I2S starts a word one bit after either sync edge
// - slave AC-Link starts tag slot one bit after sync sampled high
// - slave runs a whole frame, ignoring sync until it completes
// - long words span consecutive enabled slots, most significant part first
// - word-size field holds word length minus one
// - buffer-length field holds words per transfer minus one
// - mode code 01 selects I2S, master sync at 50 percent duty
// - interface flag set on every buffer transfer
`default_nettype none

package csi_pkg;

    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_TSLOT = 8'h0C;
    localparam logic [7:0] OFF_RSLOT = 8'h10;
    localparam logic [7:0] OFF_TXH = 8'h20;
    localparam logic [7:0] OFF_RXH = 8'h30;

    localparam int EN_BIT = 15;
    localparam int SDIR_BIT = 8;
    localparam int MODE_LSB = 0;
    localparam int WS_LSB = 0;
    localparam int FSG_LSB = 5;
    localparam int BUFFER_LENGTH_FIELD_LSB = 10;
    localparam int TXE_BIT = 0;
    localparam int RXF_BIT = 2;
    localparam int OVF_BIT = 3;
    localparam int SLOT_LSB = 7;
    localparam int IRQ_BIT = 15;

    localparam logic [1:0] MODE_I2S = 2'h1;
    localparam logic [4:0] STOP_MARGIN = 5'h03;
    localparam logic [3:0] SLOT_IDLE = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } state_type;

    typedef struct packed {
        logic enable;
        logic syncDir;
        logic [1:0] mode;
        logic [3:0] wordSize;
        logic [3:0] frameLen;
        logic [1:0] bufLen;
        logic [15:0] txSlots;
        logic [15:0] rxSlots;
        logic [3:0][15:0] txHold;
        logic [3:0][15:0] rxHold;
        logic [3:0][15:0] tx_holding_reg;
        logic [3:0][15:0] rx_holding_reg;
        logic txEmpty;
        logic rxFull;
        logic rxOvf;
        logic irqFlag;
        state_type state;
        logic [3:0] bitCnt;
        logic [3:0] slotCnt;
        logic [1:0] bufIdx;
        logic rxPend;
        logic [15:0] txShift;
        logic [15:0] rxShift;
        logic fsOut;
        logic fsLast;
        logic armed;
        logic pinEn;
        logic stopSeen;
        logic lateStop;
        logic [31:0] rdata;
    } core_type;

endpackage

`default_nettype wire

// File: verilog/pin_sync.sv
// Purpose: two-stage synchroniser with a delayed copy for edge finding
// Assumes: inputs are asynchronous to clk
// Notes: only the second stage and its copy are visible outside
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] qLast
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] last;
    } sync_state_type;

    sync_state_type sReg, sNext;

    always_comb begin
        sNext.meta = d;
        sNext.stable = sReg.meta;
        sNext.last = sReg.stable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sReg <= '0;
        end else begin
            sReg <= sNext;
        end
    end

    assign q = sReg.stable;
    assign qLast = sReg.last;

endmodule // pin_sync

`default_nettype wire

// File: verilog/converter_serial_iface.sv
// Purpose: framing, start-up, shutdown and buffering of the converter link
// Assumes: bit clock from the codec, sampled by ref_clk at 100 MHz
// Notes: data changes on bit clock falling edge, sampled on rising edge
`default_nettype none

module converter_serial_iface #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialBitClock,
    input wire logic frameSyncIn,
    output logic frameSyncOut,
    output logic frameSyncOe,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic ifaceIrq
);

    csi_pkg::core_type stReg, stNext;

    logic [2:0] pinNow, pinLast;
    logic rise, fall, syncHit, slotLast, bitLast, slotUsed;
    logic doXfer, newSlot, apbSetup, apbAcc, mapped, txRange, rxRange;
    logic [7:0] addr8;
    logic [3:0] nextSlot;
    logic [31:0] rdMux;

    // bit clock, frame sync and data in, all from the codec's domain
    pin_sync #(.W(3)) u_pins (
        .clk(ref_clk),
        .rst(sys_rst),
        .d({serialBitClock, frameSyncIn, serialDataIn}),
        .q(pinNow),
        .qLast(pinLast)
    );

    assign rise = pinNow[2] & ~pinLast[2];
    assign fall = ~pinNow[2] & pinLast[2];

    assign addr8 = 8'(paddr);
    assign apbSetup = psel & ~penable;
    assign apbAcc = psel & penable;
    assign txRange = {addr8[7:4], 4'h0} == csi_pkg::OFF_TXH && addr8[1:0] == 2'h0;
    assign rxRange = {addr8[7:4], 4'h0} == csi_pkg::OFF_RXH && addr8[1:0] == 2'h0;
    assign mapped = addr8 == csi_pkg::OFF_CTRL1 || addr8 == csi_pkg::OFF_CTRL2
        || addr8 == csi_pkg::OFF_STATUS || addr8 == csi_pkg::OFF_TSLOT
        || addr8 == csi_pkg::OFF_RSLOT || txRange || rxRange;

    // frame position
    assign bitLast = stReg.bitCnt == stReg.wordSize;
    assign slotLast = stReg.slotCnt == stReg.frameLen;
    assign slotUsed = stReg.txSlots[stReg.slotCnt] | stReg.rxSlots[stReg.slotCnt];
    assign nextSlot = slotLast ? 4'h0 : 4'(stReg.slotCnt + 4'h1);

    // I2S answers either sync edge, the other modes a high level
    assign syncHit = stReg.enable && stReg.syncDir && rise
        && (stReg.mode == csi_pkg::MODE_I2S ? pinNow[1] != stReg.fsLast
                                            : pinNow[1]);

    always_comb begin
        rdMux = 32'h0000_0000;
        if (txRange) begin
            rdMux[15:0] = stReg.txHold[addr8[3:2]];
        end else if (rxRange) begin
            rdMux[15:0] = stReg.rxHold[addr8[3:2]];
        end else begin
            case (addr8)
                csi_pkg::OFF_CTRL1: begin
                    rdMux[csi_pkg::EN_BIT] = stReg.enable;
                    rdMux[csi_pkg::SDIR_BIT] = stReg.syncDir;
                    rdMux[csi_pkg::MODE_LSB+:2] = stReg.mode;
                end
                csi_pkg::OFF_CTRL2: begin
                    rdMux[csi_pkg::WS_LSB+:4] = stReg.wordSize;
                    rdMux[csi_pkg::FSG_LSB+:4] = stReg.frameLen;
                    rdMux[csi_pkg::BUFFER_LENGTH_FIELD_LSB+:2] = stReg.bufLen;
                end
                csi_pkg::OFF_STATUS: begin
                    rdMux[csi_pkg::TXE_BIT] = stReg.txEmpty;
                    rdMux[csi_pkg::RXF_BIT] = stReg.rxFull;
                    rdMux[csi_pkg::OVF_BIT] = stReg.rxOvf;
                    rdMux[csi_pkg::SLOT_LSB+:4] = stReg.slotCnt;
                    rdMux[csi_pkg::IRQ_BIT] = stReg.irqFlag;
                end
                csi_pkg::OFF_TSLOT: rdMux[15:0] = stReg.txSlots;
                csi_pkg::OFF_RSLOT: rdMux[15:0] = stReg.rxSlots;
                default: rdMux = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        stNext = stReg;
        doXfer = 1'b0;
        newSlot = 1'b0;

        // read data captured in the setup cycle so prdata comes from a flop
        if (apbSetup) begin
            stNext.rdata = rdMux;
        end

        if (apbAcc && pwrite && mapped) begin
            if (txRange) begin
                stNext.txHold[addr8[3:2]] = pwdata[15:0];
                stNext.txEmpty = 1'b0;
            end else begin
                case (addr8)
                    csi_pkg::OFF_CTRL1: begin
                        stNext.enable = pwdata[csi_pkg::EN_BIT];
                        stNext.syncDir = pwdata[csi_pkg::SDIR_BIT];
                        stNext.mode = pwdata[csi_pkg::MODE_LSB+:2];
                    end
                    csi_pkg::OFF_CTRL2: begin
                        stNext.wordSize = pwdata[csi_pkg::WS_LSB+:4];
                        stNext.frameLen = pwdata[csi_pkg::FSG_LSB+:4];
                        stNext.bufLen = pwdata[csi_pkg::BUFFER_LENGTH_FIELD_LSB+:2];
                    end
                    // write one to clear the interface flag
                    csi_pkg::OFF_STATUS: begin
                        stNext.irqFlag = stReg.irqFlag & ~pwdata[csi_pkg::IRQ_BIT];
                    end
                    csi_pkg::OFF_TSLOT: stNext.txSlots = pwdata[15:0];
                    csi_pkg::OFF_RSLOT: stNext.rxSlots = pwdata[15:0];
                    default: ;
                endcase
            end
        end

        if (apbAcc && !pwrite && rxRange) begin
            stNext.rxFull = 1'b0;
            stNext.rxOvf = 1'b0;
        end

        case (stReg.state)
            csi_pkg::ST_IDLE: begin
                stNext.slotCnt = csi_pkg::SLOT_IDLE;
                stNext.pinEn = 1'b0;
                stNext.fsOut = 1'b0;
                if (stReg.enable) begin
                    // both roles load now; a slave just holds them until sync
                    stNext.tx_holding_reg = stReg.txHold;
                    stNext.txEmpty = 1'b1;
                    stNext.irqFlag = 1'b1;
                    stNext.bitCnt = 4'h0;
                    stNext.bufIdx = 2'h0;
                    stNext.armed = 1'b0;
                    stNext.stopSeen = 1'b0;
                    stNext.lateStop = 1'b0;
                    stNext.pinEn = 1'b1;
                    stNext.state = csi_pkg::ST_WAIT;
                end
            end
            csi_pkg::ST_WAIT: begin
                if (rise) begin
                    stNext.fsLast = pinNow[1];
                    if (syncHit) begin
                        stNext.armed = 1'b1;
                    end
                end
                if (!stReg.enable) begin
                    // nothing in flight, so stop at once
                    stNext.state = csi_pkg::ST_IDLE;
                    stNext.armed = 1'b0;
                    stNext.fsOut = 1'b0;
                end else if (fall && stReg.armed) begin
                    stNext.state = csi_pkg::ST_RUN;
                    stNext.armed = 1'b0;
                    stNext.bitCnt = 4'h0;
                    stNext.slotCnt = 4'h0;
                    stNext.fsOut = 1'b0;
                    newSlot = 1'b1;
                end else if (fall && !stReg.syncDir) begin
                    // one sync bit ahead of the first frame
                    stNext.fsOut = stReg.mode != csi_pkg::MODE_I2S;
                    stNext.armed = 1'b1;
                end
            end
            csi_pkg::ST_RUN: begin
                if (rise) begin
                    stNext.rxShift = {stReg.rxShift[14:0], pinNow[0]};
                    stNext.fsLast = pinNow[1];
                    // sync only counts in the frame's final bit
                    if (syncHit && slotLast && bitLast) begin
                        stNext.armed = 1'b1;
                    end
                end
                if (fall) begin
                    if (!stReg.enable && !stReg.stopSeen) begin
                        stNext.stopSeen = 1'b1;
                        stNext.lateStop = slotLast
                            && {1'b0, stReg.bitCnt} + csi_pkg::STOP_MARGIN
                               > {1'b0, stReg.wordSize};
                    end
                    if (!bitLast) begin
                        stNext.bitCnt = 4'(stReg.bitCnt + 4'h1);
                        stNext.txShift = {stReg.txShift[14:0], 1'b0};
                        if (stReg.enable && !stReg.syncDir
                            && stReg.bitCnt + 4'h1 == stReg.wordSize) begin
                            if (stReg.mode == csi_pkg::MODE_I2S) begin
                                stNext.fsOut = nextSlot[0];
                            end else begin
                                stNext.fsOut = slotLast;
                            end
                            if (slotLast) begin
                                stNext.armed = 1'b1;
                            end
                        end
                    end else begin
                        stNext.bitCnt = 4'h0;
                        if (stReg.mode != csi_pkg::MODE_I2S) begin
                            stNext.fsOut = 1'b0;
                        end
                        if (slotUsed) begin
                            if (stReg.rxSlots[stReg.slotCnt]) begin
                                stNext.rx_holding_reg[stReg.bufIdx] = stReg.rxShift
                                    & (16'hFFFF >> (4'hF - stReg.wordSize));
                                stNext.rxPend = 1'b1;
                            end
                            stNext.bufIdx = 2'(stReg.bufIdx + 2'h1);
                            if (stReg.bufIdx == stReg.bufLen) begin
                                doXfer = 1'b1;
                            end
                        end
                        if (!slotLast) begin
                            stNext.slotCnt = nextSlot;
                            newSlot = 1'b1;
                        end else begin
                            if (stNext.bufIdx != 2'h0) begin
                                doXfer = 1'b1;
                            end
                            stNext.slotCnt = 4'h0;
                            if (!stReg.enable && !stNext.lateStop) begin
                                stNext.state = csi_pkg::ST_IDLE;
                                stNext.pinEn = 1'b0;
                                stNext.armed = 1'b0;
                                stNext.fsOut = 1'b0;
                                if (stNext.rxPend) begin
                                    doXfer = 1'b1;
                                end
                            end else if (!stReg.enable) begin
                                // disabled too late: one more frame, no sync
                                stNext.lateStop = 1'b0;
                                newSlot = 1'b1;
                            end else if (stNext.armed) begin
                                stNext.armed = 1'b0;
                                newSlot = 1'b1;
                            end else begin
                                stNext.state = csi_pkg::ST_WAIT;
                            end
                        end
                    end
                end
            end
            default: begin
                stNext.state = csi_pkg::ST_IDLE;
            end
        endcase

        // buffer transfer: set wins over any software clear this cycle
        if (doXfer) begin
            stNext.tx_holding_reg = stReg.txHold;
            stNext.bufIdx = 2'h0;
            if (stReg.txSlots != 16'h0000) begin
                stNext.txEmpty = 1'b1;
            end
            if (stNext.rxPend) begin
                stNext.rxHold = stNext.rx_holding_reg;
                stNext.rxOvf = stNext.rxOvf | stReg.rxFull;
                stNext.rxFull = 1'b1;
                stNext.rxPend = 1'b0;
            end
            stNext.irqFlag = 1'b1;
        end

        // right-justified word, sent most significant bit first
        if (newSlot) begin
            if (stReg.txSlots[stNext.slotCnt]) begin
                stNext.txShift = stNext.tx_holding_reg[stNext.bufIdx]
                    << (4'hF - stReg.wordSize);
            end else begin
                stNext.txShift = 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    // no wait states: read data settles in the setup cycle
    assign pready = apbAcc;
    assign pslverr = apbAcc & ~mapped;
    assign prdata = stReg.rdata;
    assign frameSyncOut = stReg.fsOut;
    assign frameSyncOe = stReg.pinEn & ~stReg.syncDir;
    assign serialDataOut = stReg.txShift[15];
    assign serialDataOe = stReg.pinEn;
    assign ifaceIrq = stReg.irqFlag;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    property p_idle_slot;
        stReg.state == csi_pkg::ST_IDLE && !stReg.enable |=> stReg.slotCnt == 4'h0;
    endproperty
    a_idle_slot: assert property (p_idle_slot) else $error("slot not zero in idle");
    property p_start_empty;
        stReg.state == csi_pkg::ST_IDLE && stReg.enable
            |=> stReg.txEmpty && stReg.irqFlag && stReg.state == csi_pkg::ST_WAIT;
    endproperty
    a_start_empty: assert property (p_start_empty)
        else $error("enable did not flag empty");
    property p_tx_write;
        apbAcc && pwrite && txRange && !doXfer && stReg.state != csi_pkg::ST_IDLE
            |=> !stReg.txEmpty;
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("tx write left empty set");
    property p_rx_read;
        apbAcc && !pwrite && rxRange && !doXfer |=> !stReg.rxFull;
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("rx read left full set");
    property p_idle_pins;
        stReg.state == csi_pkg::ST_IDLE ##1 stReg.state == csi_pkg::ST_IDLE
            |-> !serialDataOe && !frameSyncOe && !frameSyncOut;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("pins held in idle");
    property p_slave_quiet;
        stReg.syncDir |-> !frameSyncOe;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives sync");
    property p_xfer_flag;
        doXfer |=> stReg.irqFlag && stReg.bufIdx == 2'h0;
    endproperty
    a_xfer_flag: assert property (p_xfer_flag) else $error("transfer without flag");
    property p_no_arm_midframe;
        stReg.state == csi_pkg::ST_RUN && !stReg.armed && stReg.syncDir
            && !(slotLast && bitLast) |=> !stReg.armed;
    endproperty
    a_no_arm_midframe: assert property (p_no_arm_midframe)
        else $error("sync taken mid-frame");
    property p_no_sync_off;
        !stReg.enable && stReg.state == csi_pkg::ST_WAIT |=> !stReg.armed;
    endproperty
    a_no_sync_off: assert property (p_no_sync_off)
        else $error("sync taken while disabled");
    property p_run_needs_arm;
        stReg.state == csi_pkg::ST_WAIT && !stReg.armed |=> stReg.state != csi_pkg::ST_RUN;
    endproperty
    a_run_needs_arm: assert property (p_run_needs_arm) else $error("frame without sync");

endmodule // converter_serial_iface

`default_nettype wire

// File: test/codec_model.sv
// Purpose: codec model giving bit clock, frame sync and serial data
// Assumes: codec is clock and frame master, 125 ns bit clock
// Notes: clock stands low between frames
`default_nettype none
module codec_model (
    output logic bitClk,
    output logic sync,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        bitClk = 1'h0;
        sync = 1'h0;
        sdi = 1'h0;
    end
    // n bits a frame, so frame length follows the caller's setup
    task automatic frame(input int n, input logic [15:0] d, output logic [15:0] got);
        got = 16'h0;
        sync = 1'h1;
        #62.5 bitClk = 1'h1;
        #62.5 bitClk = 1'h0;
        sync = 1'h0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = d[i];
            #62.5 bitClk = 1'h1;
            got[i] = sdo;
            #62.5 bitClk = 1'h0;
        end
        sdi = ~sdi;
    endtask
endmodule // codec_model
`default_nettype wire

// File: test/tb_converter_serial_iface.sv
// Purpose: self-checking bench of the converter serial interface
// Assumes: codec model supplies bit clock, and frame sync in the slave tests
// Notes: start-up, buffering, shutdown and long words
`default_nettype none
module tb_converter_serial_iface;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic bitClk, syncIn, sdi, fsOut, fsOe, sdo, sdoOe, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] got;
    int badCount = 0;
    int nChecks = 0;
    // released data line is pulled low; released sync line follows the codec
    wire logic syncWire = fsOe ? fsOut : syncIn;
    wire logic sdoWire = sdoOe ? sdo : 1'h0;
    converter_serial_iface i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialBitClock(bitClk),
        .frameSyncIn(syncWire), .frameSyncOut(fsOut), .frameSyncOe(fsOe),
        .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOe(sdoOe), .ifaceIrq(irq));
    codec_model i_codec (.bitClk(bitClk), .sync(syncIn), .sdi(sdi), .sdo(sdoWire));
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic testDone;
        if (badCount == 0 && nChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        nChecks++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        apb(1'h0, a, 32'h0);
        chk(r[15:0] & m, e);
    endtask
    // settle time lets the last bit clock fall reach the engine
    task automatic run(input int n, input logic [15:0] d, input logic [15:0] e);
        i_codec.frame(n, d, got);
        repeat (5) @(posedge ref_clk);
        chk(got, e);
    endtask
    initial begin
        #50000;
        badCount++;
        testDone();
    end
    initial begin
        sys_rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        rd(8'h40, 16'hFFFF, 16'h0);
        chk({15'h0, err}, 16'h1);
        wr(csi_pkg::OFF_CTRL2, 32'h7);
        wr(csi_pkg::OFF_TSLOT, 32'h1);
        wr(csi_pkg::OFF_RSLOT, 32'h1);
        wr(csi_pkg::OFF_TXH, 32'hA5);
        run(8, 16'h5A, 16'h0);
        rd(csi_pkg::OFF_RXH, 16'hFFFF, 16'h0);
        wr(csi_pkg::OFF_CTRL1, 32'h8100);
        rd(csi_pkg::OFF_STATUS, 16'h8005, 16'h8001);
        chk({irq, fsOe}, 16'h2);
        wr(csi_pkg::OFF_TXH, 32'h3C);
        rd(csi_pkg::OFF_STATUS, 16'h0001, 16'h0);
        wr(csi_pkg::OFF_STATUS, 32'h8000);
        run(8, 16'h5A, 16'hA5);
        rd(csi_pkg::OFF_STATUS, 16'h8005, 16'h8005);
        rd(csi_pkg::OFF_RXH, 16'hFFFF, 16'h5A);
        rd(csi_pkg::OFF_STATUS, 16'h0004, 16'h0);
        run(8, 16'hC3, 16'h3C);
        wr(csi_pkg::OFF_CTRL1, 32'h0100);
        rd(csi_pkg::OFF_STATUS, 16'h0780, 16'h0);
        chk({fsOe, sdoOe}, 16'h0);
        run(8, 16'h77, 16'h0);
        rd(csi_pkg::OFF_RXH, 16'hFFFF, 16'hC3);
        wr(csi_pkg::OFF_CTRL2, 32'h0427);
        wr(csi_pkg::OFF_TXH, 32'h12);
        wr(csi_pkg::OFF_TXH + 8'h04, 32'h34);
        wr(csi_pkg::OFF_TSLOT, 32'h3);
        wr(csi_pkg::OFF_RSLOT, 32'h3);
        wr(csi_pkg::OFF_CTRL1, 32'h8100);
        run(16, 16'hBEEF, 16'h1234);
        rd(csi_pkg::OFF_RXH, 16'hFFFF, 16'hBE);
        rd(csi_pkg::OFF_RXH + 8'h04, 16'hFFFF, 16'hEF);
        // master: the sync bit costs one bit clock ahead of the word
        wr(csi_pkg::OFF_CTRL1, 32'h0);
        wr(csi_pkg::OFF_CTRL2, 32'h7);
        wr(csi_pkg::OFF_TXH, 32'h96);
        wr(csi_pkg::OFF_CTRL1, 32'h8000);
        run(9, 16'h1A5, 16'h96);
        chk({fsOe, sdoOe}, 16'h3);
        rd(csi_pkg::OFF_RXH, 16'hFFFF, 16'hA5);
        // disabled early in the next frame: it finishes, then pins let go
        wr(csi_pkg::OFF_CTRL1, 32'h0);
        run(8, 16'h0, 16'h2C);
        rd(csi_pkg::OFF_STATUS, 16'h0780, 16'h0);
        chk({fsOe, sdoOe}, 16'h0);
        testDone();
    end
endmodule // tb_converter_serial_iface
`default_nettype wire
